// ---- bit_manip_pkg.sv ----
// Package with operation codes, widths and reset values of the bit manipulation unit
package bit_manip_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int IDX_W = 3;
    localparam int OP_W = 3;

    // ==========================================================
    // Operation codes presented by the decoder
    localparam logic [OP_W-1:0] OP_NONE = 3'h0;
    localparam logic [OP_W-1:0] OP_COND_BIT_CLEAR = 3'h1;
    localparam logic [OP_W-1:0] OP_BIT_INVERT = 3'h2;
    localparam logic [OP_W-1:0] OP_BIT_TEST = 3'h3;
    localparam logic [OP_W-1:0] OP_CARRY_AND_BIT = 3'h4;
    localparam logic [OP_W-1:0] OP_CARRY_AND_INVERTED_BIT = 3'h5;
    localparam logic [OP_W-1:0] OP_CARRY_OR_BIT = 3'h6;

    // ==========================================================
    // Reset values of the result registers
    localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
    localparam logic FLAG_RST = 1'h0;
    localparam logic STROBE_RST = 1'h0;

endpackage

// ---- bit_sel_if.sv ----
// Interface carrying the bit index, operand and decoded bit between the modules
`timescale 1ns/100ps
interface bit_sel_if;
    logic [bit_manip_pkg::IDX_W-1:0] index;
    logic [bit_manip_pkg::DATA_W-1:0] operand;
    logic [bit_manip_pkg::DATA_W-1:0] mask;
    logic selected_bit;

    // Requester drives index and operand, decoder answers
    modport requester (
        output index,
        output operand,
        input mask,
        input selected_bit
    );
    modport decoder (
        input index,
        input operand,
        output mask,
        output selected_bit
    );
endinterface

// ---- bit_select_decoder.sv ----
// One-hot mask decoder and bit picker for the selected operand bit
`timescale 1ns/100ps
module bit_select_decoder (
    bit_sel_if.decoder sel
);

    // ==========================================================
    // One-hot decode, used for both the mask and the bit pick
    function automatic logic [bit_manip_pkg::DATA_W-1:0] one_hot(
        input logic [bit_manip_pkg::IDX_W-1:0] idx
    );
        logic [bit_manip_pkg::DATA_W-1:0] m;
        m = '0;
        m[idx] = 1'h1;
        return m;
    endfunction

    // Pure combinational: no added latency on the operand path
    always_comb begin
        sel.mask = one_hot(sel.index);
        sel.selected_bit = |(sel.operand & one_hot(sel.index));
    end

endmodule

// ---- bit_manipulation_unit.sv ----
// Byte-wide bit manipulation datapath: conditional clear, invert, test and carry ops
// Function
// - Conditional clear forces selected bit to 0; index from immediate or register.
// - Condition for the conditional clear is taken from the zero flag.
// - Bit invert complements exactly one selected bit; index immediate or register.
// - Bit test loads zero flag with inverse of selected bit; operand unchanged.
// - Carry-AND sets carry to carry AND selected bit; immediate index only.
// - Carry-AND-inverse sets carry to carry AND NOT selected bit; immediate index.
// - Carry-OR sets carry to carry OR selected bit; immediate index only.
`timescale 1ns/100ps
module bit_manipulation_unit (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Operation request from the decoder
    input wire logic i_valid,
    input wire logic [bit_manip_pkg::OP_W-1:0] i_op,
    input wire logic [bit_manip_pkg::IDX_W-1:0] i_bit_imm,
    input wire logic [bit_manip_pkg::DATA_W-1:0] i_bit_reg,
    input wire logic i_index_from_reg,
    input wire logic i_clear_when_zero,
    // Operand and current flags
    input wire logic [bit_manip_pkg::DATA_W-1:0] i_operand,
    input wire logic i_zero_flag,
    input wire logic i_carry_flag,
    // Results
    output logic o_done,
    output logic [bit_manip_pkg::DATA_W-1:0] o_result,
    output logic o_result_we,
    output logic o_zero_flag,
    output logic o_zero_we,
    output logic o_carry_flag,
    output logic o_carry_we
);

    // ==========================================================
    // Operation decode helpers
    // True for the three ops that fold a bit into the carry flag
    function automatic logic is_carry_op(
        input logic [bit_manip_pkg::OP_W-1:0] op
    );
        logic hit;
        hit = (op == bit_manip_pkg::OP_CARRY_AND_BIT) ||
              (op == bit_manip_pkg::OP_CARRY_AND_INVERTED_BIT) ||
              (op == bit_manip_pkg::OP_CARRY_OR_BIT);
        return hit;
    endfunction

    // True when a live request carries the given op code
    function automatic logic op_hit(
        input logic valid,
        input logic [bit_manip_pkg::OP_W-1:0] op,
        input logic [bit_manip_pkg::OP_W-1:0] code
    );
        logic hit;
        hit = valid && (op == code);
        return hit;
    endfunction

    // ==========================================================
    // Decoded request strobes
    logic do_clear;
    logic do_invert;
    logic do_test;
    logic do_carry_and;
    logic do_carry_andn;
    logic do_carry_or;

    // One strobe per op; op codes 0 and 7 raise none and only complete
    // Decoding once here keeps every state group below free of op-code compares
    assign do_clear = op_hit(i_valid, i_op, bit_manip_pkg::OP_COND_BIT_CLEAR);
    assign do_invert = op_hit(i_valid, i_op, bit_manip_pkg::OP_BIT_INVERT);
    assign do_test = op_hit(i_valid, i_op, bit_manip_pkg::OP_BIT_TEST);
    assign do_carry_and = op_hit(i_valid, i_op, bit_manip_pkg::OP_CARRY_AND_BIT);
    assign do_carry_andn = op_hit(i_valid, i_op, bit_manip_pkg::OP_CARRY_AND_INVERTED_BIT);
    assign do_carry_or = op_hit(i_valid, i_op, bit_manip_pkg::OP_CARRY_OR_BIT);

    // ==========================================================
    // Bit index selection and decode
    bit_sel_if sel ();

    logic carry_op;
    logic cond_met;

    // Carry ops only take the immediate index; a register index is ignored for them
    assign carry_op = is_carry_op(i_op);
    assign sel.index = (i_index_from_reg && !carry_op) ?
                       i_bit_reg[bit_manip_pkg::IDX_W-1:0] : i_bit_imm;
    assign sel.operand = i_operand;
    // Condition true when Z matches the polarity the decoder asked for
    assign cond_met = (i_zero_flag == i_clear_when_zero);

    // Shared decoder: one mask for the byte ops, one picked bit for the flag ops
    bit_select_decoder u_dec (
        .sel(sel)
    );

    // ==========================================================
    // Completion strobe group
    logic done_r;
    logic done_nxt;

    // Every taken request completes one cycle later, whatever its op code
    always_comb begin
        done_nxt = i_valid;
    end

    // Resets low so no phantom completion is seen as reset lifts
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            done_r <= bit_manip_pkg::STROBE_RST;
        end else begin
            done_r <= done_nxt;
        end
    end

    // ==========================================================
    // Result byte group: conditional clear and bit invert
    logic [bit_manip_pkg::DATA_W-1:0] result_r;
    logic [bit_manip_pkg::DATA_W-1:0] result_nxt;
    logic result_we_r;
    logic result_we_nxt;

    // The byte holds between clear and invert requests; the write strobe lasts one cycle only
    always_comb begin
        result_nxt = result_r;
        result_we_nxt = 1'h0;
        if (do_clear) begin
            // An unmet condition shows the untouched byte but never writes it
            result_nxt = i_operand;
            if (cond_met) begin
                result_nxt = i_operand & ~sel.mask;
                result_we_nxt = 1'h1;
            end
        end else if (do_invert) begin
            result_nxt = i_operand ^ sel.mask;
            result_we_nxt = 1'h1;
        end
    end

    // Registers only; all decisions live in the block above
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            result_r <= bit_manip_pkg::RESULT_RST;
            result_we_r <= bit_manip_pkg::STROBE_RST;
        end else begin
            result_r <= result_nxt;
            result_we_r <= result_we_nxt;
        end
    end

    // ==========================================================
    // Zero flag group: bit test
    logic zero_r;
    logic zero_nxt;
    logic zero_we_r;
    logic zero_we_nxt;

    // Only the test writes Z; the operand passes through untouched
    // The incoming Z is not folded in: the test overwrites it outright
    always_comb begin
        zero_nxt = zero_r;
        zero_we_nxt = 1'h0;
        if (do_test) begin
            zero_nxt = ~sel.selected_bit;
            zero_we_nxt = 1'h1;
        end
    end

    // Registers only
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            zero_r <= bit_manip_pkg::FLAG_RST;
            zero_we_r <= bit_manip_pkg::STROBE_RST;
        end else begin
            zero_r <= zero_nxt;
            zero_we_r <= zero_we_nxt;
        end
    end

    // ==========================================================
    // Carry flag group: carry-AND, carry-AND-inverse and carry-OR
    logic carry_r;
    logic carry_nxt;
    logic carry_we_r;
    logic carry_we_nxt;

    // The three carry ops exclude each other by op code, so priority is moot
    always_comb begin
        carry_nxt = carry_r;
        carry_we_nxt = 1'h0;
        if (do_carry_and) begin
            carry_nxt = i_carry_flag & sel.selected_bit;
            carry_we_nxt = 1'h1;
        end else if (do_carry_andn) begin
            carry_nxt = i_carry_flag & ~sel.selected_bit;
            carry_we_nxt = 1'h1;
        end else if (do_carry_or) begin
            carry_nxt = i_carry_flag | sel.selected_bit;
            carry_we_nxt = 1'h1;
        end
    end

    // Registers only
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            carry_r <= bit_manip_pkg::FLAG_RST;
            carry_we_r <= bit_manip_pkg::STROBE_RST;
        end else begin
            carry_r <= carry_nxt;
            carry_we_r <= carry_we_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // Every output comes straight from a flip-flop, so no glitch reaches write-back
    assign o_done = done_r;
    assign o_result = result_r;
    assign o_result_we = result_we_r;
    assign o_zero_flag = zero_r;
    assign o_zero_we = zero_we_r;
    assign o_carry_flag = carry_r;
    assign o_carry_we = carry_we_r;

endmodule

// ---- bit_manipulation_unit_asserts.sv ----
// Concurrent checks on the ports of the bit manipulation unit
`timescale 1ns/100ps
module bit_manipulation_unit_asserts (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Request seen by the unit
    input wire logic i_valid,
    input wire logic [2:0] i_op,
    input wire logic [2:0] i_bit_imm,
    input wire logic [7:0] i_bit_reg,
    input wire logic i_index_from_reg,
    input wire logic i_clear_when_zero,
    input wire logic [7:0] i_operand,
    input wire logic i_zero_flag,
    input wire logic i_carry_flag,
    // Results driven by the unit
    input wire logic o_done,
    input wire logic [7:0] o_result,
    input wire logic o_result_we,
    input wire logic o_zero_flag,
    input wire logic o_zero_we,
    input wire logic o_carry_flag,
    input wire logic o_carry_we
);
    // ==========
    // Effective index, one-hot mask and clear condition of the request
    logic [2:0] ix;
    logic [7:0] hot;
    logic met;
    assign ix = i_index_from_reg ? i_bit_reg[2:0] : i_bit_imm;
    assign hot = 8'h01 << ix;
    assign met = i_zero_flag == i_clear_when_zero;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_clear_bit: assert property (i_valid && i_op == 3'h1 && met |=> o_result_we
        && o_result == ($past(i_operand) & ~$past(hot))) else $error("clear wrong");
    a_clear_cond: assert property (i_valid && i_op == 3'h1 |=>
        o_result_we == $past(met)) else $error("clear condition wrong");
    a_invert_bit: assert property (i_valid && i_op == 3'h2 |=> o_result_we
        && o_result == ($past(i_operand) ^ $past(hot))) else $error("invert wrong");
    a_test_zero: assert property (i_valid && i_op == 3'h3 |=> o_zero_we && !o_result_we
        && o_zero_flag == !$past(|(i_operand & hot))) else $error("test wrong");
    a_carry_and: assert property (i_valid && i_op == 3'h4 |=> o_carry_we
        && o_carry_flag == $past(i_carry_flag & i_operand[i_bit_imm])) else $error("and wrong");
    a_carry_andn: assert property (i_valid && i_op == 3'h5 |=> o_carry_we
        && o_carry_flag == $past(i_carry_flag & !i_operand[i_bit_imm])) else $error("andn wrong");
    a_carry_or: assert property (i_valid && i_op == 3'h6 |=> o_carry_we
        && o_carry_flag == $past(i_carry_flag | i_operand[i_bit_imm])) else $error("or wrong");
    a_skip_write: assert property (i_valid && i_op == 3'h1 && !met |=> !o_result_we
        && o_result == $past(i_operand)) else $error("skipped clear wrote");
    a_done_follows: assert property (i_valid |=> o_done)
        else $error("request did not complete");
    a_idle_quiet: assert property (!i_valid |=> !o_done && !o_result_we
        && !o_zero_we && !o_carry_we) else $error("strobe without request");
    cover property (i_valid && i_op == 3'h1 && !met);
    cover property (i_valid ##1 i_valid);
    cover property (i_valid && i_op == 3'h3 && i_index_from_reg);
endmodule
bind bit_manipulation_unit bit_manipulation_unit_asserts chk_u (.*);

// ---- bmu_feeder.sv ----
// Decoder side model that presents operations to the unit
`timescale 1ns/100ps
module bmu_feeder (
    // Clock
    input wire logic i_sys_clk,
    // Request handed to the unit
    output logic o_valid,
    output logic o_from_reg,
    output logic o_pol,
    output logic o_z,
    output logic o_c,
    output logic [2:0] o_op,
    output logic [2:0] o_imm,
    output logic [7:0] o_reg,
    output logic [7:0] o_opnd
);
    // ==========
    // Request and idle cycles, changed only just after a rising edge
    initial {o_valid, o_from_reg, o_pol, o_z, o_c, o_op, o_imm, o_reg, o_opnd} = '0;
    task automatic issue(input logic [2:0] op, imm, input logic [7:0] rg, od,
        input logic fr, pl, z, c);
        @(posedge i_sys_clk);
        {o_valid, o_op, o_imm, o_reg, o_opnd} <= {1'h1, op, imm, rg, od};
        {o_from_reg, o_pol, o_z, o_c} <= {fr, pl, z, c};
    endtask
    // Idle operand flips so a stale byte is never mistaken for a live one
    task automatic idle();
        @(posedge i_sys_clk);
        o_valid <= 1'h0;
        o_opnd <= ~o_opnd;
    endtask
endmodule

// ---- bit_manipulation_unit_bench.sv ----
// Self-checking bench of the bit manipulation unit against a reference model
`timescale 1ns/100ps
module bit_manipulation_unit_bench;
    typedef struct {logic [7:0] r; logic rw, zw, cw, z, c;} exp_s;
    logic i_sys_clk = 1'h0, i_rst = 1'h1;
    logic v, fr, pl, z, c, done, rwe, zf, zwe, cf, cwe;
    logic [2:0] op, imm;
    logic [7:0] rg, od, res, s = 8'h3F;
    exp_s q[$];
    exp_s e;
    exp_s h = '{8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
    int bad_count = 0, n_compared = 0;
    // ==========
    // Clock, feeder and unit
    always #5 i_sys_clk = ~i_sys_clk;
    bmu_feeder drv_u (.i_sys_clk(i_sys_clk), .o_valid(v), .o_from_reg(fr), .o_pol(pl),
        .o_z(z), .o_c(c), .o_op(op), .o_imm(imm), .o_reg(rg), .o_opnd(od));
    bit_manipulation_unit dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_valid(v), .i_op(op),
        .i_bit_imm(imm), .i_bit_reg(rg), .i_index_from_reg(fr), .i_clear_when_zero(pl),
        .i_operand(od), .i_zero_flag(z), .i_carry_flag(c), .o_done(done), .o_result(res),
        .o_result_we(rwe), .o_zero_flag(zf), .o_zero_we(zwe), .o_carry_flag(cf),
        .o_carry_we(cwe));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk8(input logic [7:0] ex, got);
        n_compared++;
        if (ex !== got) begin
            bad_count++;
            $display("BAD %0t exp %h got %h", $time, ex, got);
        end
    endtask
    task automatic chk4(input logic [3:0] ex, got);
        chk8({4'h0, ex}, {4'h0, got});
    endtask
    // Model: random request, predicted outputs queued until completion
    task automatic go();
        logic [7:0] a, b, w;
        logic [2:0] ix;
        exp_s x;
        a = lfsr(s);
        b = lfsr(a);
        w = lfsr(b);
        s = lfsr(w);
        ix = a[6] ? b[2:0] : a[5:3];
        x = '{h.r, 1'h0, 1'h0, 1'h0, h.z, h.c};
        case (a[2:0])
            3'h1: begin
                x.r = w;
                x.rw = s[0] == a[7];
                if (x.rw) x.r[ix] = 1'h0;
            end
            3'h2: {x.r, x.rw} = {w ^ (8'h01 << ix), 1'h1};
            3'h3: {x.z, x.zw} = {~w[ix], 1'h1};
            3'h4: {x.c, x.cw} = {s[1] & w[a[5:3]], 1'h1};
            3'h5: {x.c, x.cw} = {s[1] & ~w[a[5:3]], 1'h1};
            3'h6: {x.c, x.cw} = {s[1] | w[a[5:3]], 1'h1};
            default: ;
        endcase
        h = x;
        q.push_back(x);
        drv_u.issue(a[2:0], a[5:3], b, w, a[6], a[7], s[0], s[1]);
    endtask
    // A completion must match the oldest prediction; no strobe is allowed otherwise
    always @(negedge i_sys_clk) begin
        if (!i_rst && done === 1'h1 && q.size() > 0) begin
            e = q.pop_front();
            chk8(e.r, res);
            chk4({e.rw, e.zw, e.cw, 1'h0}, {rwe, zwe, cwe, 1'h0});
            chk4({e.z, e.c, 2'h0}, {zf, cf, 2'h0});
        end else if (!i_rst) begin
            chk4(4'h0, {done, rwe, zwe, cwe});
        end
    end
    task automatic end_of_test();
        if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Back-to-back requests with occasional idle cycles, then a bounded drain
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        for (int n = 0; n < 400; n++) begin
            go();
            if (s[7:5] == 3'h0) drv_u.idle();
        end
        drv_u.idle();
        for (int n = 0; n < 20 && q.size() > 0; n++) @(posedge i_sys_clk);
        if (q.size() > 0) bad_count++;
        end_of_test();
    end
endmodule
